// File: design/tcpu_core.sv
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
module tcpu_core
    import tcpu_pkg::*;
#(
    parameter int unsigned STACK_DEPTH = TCPU_STACK_DEPTH
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TCPU_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Program memory
    output logic [7:0] instr_addr,
    input wire logic [TCPU_INSTR_W-1:0] instr_data,
    // Port bus
    output logic [7:0] port_number,
    output logic [7:0] out_port,
    input wire logic [7:0] in_port,
    output logic read_strobe,
    output logic write_strobe,
    // Interrupt request
    input wire logic interrupt
);
    localparam int unsigned SPW = $clog2(STACK_DEPTH);
    generate
        if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
            $error("tcpu_core: STACK_DEPTH must be a power of two, at least 2");
        end
    endgenerate
    logic run;
    logic phase;
    logic take_int;
    tcpu_instr_type ir;
    logic [7:0] pc;
    logic [SPW-1:0] sp;
    logic [7:0] stack [STACK_DEPTH];
    logic [7:0] regs [8];
    logic zero;
    logic carry;
    logic int_enable;
    logic saved_zero;
    logic saved_carry;
    tcpu_instr_type fetched;
    logic [7:0] fetch_src;
    logic fetch_int;
    logic [7:0] xval;
    logic [7:0] operand;
    logic [7:0] stack_top;
    logic cond_ok;
    logic [8:0] next_sum;
    logic [8:0] next_diff;
    logic [7:0] next_result;
    logic next_zero;
    logic next_carry;
    logic reg_wr;
    logic flag_wr;
    logic do_push;
    logic do_pop;
    logic branch;
    logic [7:0] next_pc;
    assign fetched = tcpu_instr_type'(instr_data);
    assign fetch_src = regs[fetched.imm[7:TCPU_SRC_LSB]];
    // Interrupt replaces the instruction about to run
    assign fetch_int = interrupt && int_enable;
    assign xval = regs[ir.dst];
    assign operand = ir.op[TCPU_OP_REG_BIT] ? regs[ir.imm[7:TCPU_SRC_LSB]] : ir.imm;
    assign stack_top = stack[SPW'(sp - 1'b1)];
    always_comb begin
        case (ir.dst)
            TCPU_COND_ALWAYS: cond_ok = 1'b1;
            TCPU_COND_Z: cond_ok = zero;
            TCPU_COND_NZ: cond_ok = !zero;
            TCPU_COND_C: cond_ok = carry;
            TCPU_COND_NC: cond_ok = !carry;
            default: cond_ok = 1'b0;
        endcase
    end
    assign next_sum = 9'({1'b0, xval} + {1'b0, operand} + {8'h00, ir.op[0] & carry});
    assign next_diff = 9'({1'b0, xval} - {1'b0, operand} - {8'h00, ir.op[0] & carry});
    // Datapath and flag results of the instruction held in ir
    always_comb begin
        next_result = xval;
        next_carry = carry;
        reg_wr = 1'b0;
        flag_wr = 1'b0;
        do_push = 1'b0;
        do_pop = 1'b0;
        branch = 1'b0;
        next_pc = 8'(pc + 8'h01);
        if (ir.op[4] == 1'b0) begin
            reg_wr = 1'b1;
            flag_wr = 1'b1;
            case (ir.op[2:0])
                3'h0: begin
                    next_result = operand;
                    flag_wr = 1'b0;
                end
                3'h1: begin
                    next_result = xval & operand;
                    next_carry = 1'b0;
                end
                3'h2: begin
                    next_result = xval | operand;
                    next_carry = 1'b0;
                end
                3'h3: begin
                    next_result = xval ^ operand;
                    next_carry = 1'b0;
                end
                3'h4, 3'h5: begin
                    next_result = next_sum[7:0];
                    next_carry = next_sum[8];
                end
                default: begin
                    next_result = next_diff[7:0];
                    next_carry = next_diff[8];
                end
            endcase
        end else begin
            case (ir.op)
                TCPU_OP_SHIFT: begin
                    reg_wr = 1'b1;
                    flag_wr = 1'b1;
                    if (ir.imm[TCPU_SHIFT_LEFT_BIT]) begin
                        next_carry = xval[7];
                        case (ir.imm[2:0])
                            TCPU_FILL_ZERO: next_result = {xval[6:0], 1'b0};
                            TCPU_FILL_ONE: next_result = {xval[6:0], 1'b1};
                            TCPU_FILL_END: next_result = {xval[6:0], xval[0]};
                            TCPU_FILL_CARRY: next_result = {xval[6:0], carry};
                            default: next_result = {xval[6:0], xval[7]};
                        endcase
                    end else begin
                        next_carry = xval[0];
                        case (ir.imm[2:0])
                            TCPU_FILL_ZERO: next_result = {1'b0, xval[7:1]};
                            TCPU_FILL_ONE: next_result = {1'b1, xval[7:1]};
                            TCPU_FILL_END: next_result = {xval[7], xval[7:1]};
                            TCPU_FILL_CARRY: next_result = {carry, xval[7:1]};
                            default: next_result = {xval[0], xval[7:1]};
                        endcase
                    end
                end
                TCPU_OP_INPUT_K, TCPU_OP_INPUT_K | 5'h08: begin
                    // Port data lands in the destination
                    next_result = in_port;
                    reg_wr = 1'b1;
                end
                TCPU_OP_JUMP: begin
                    // Jump only on a passing test
                    branch = cond_ok;
                    next_pc = cond_ok ? ir.imm : next_pc;
                end
                TCPU_OP_CALL: begin
                    branch = cond_ok;
                    do_push = cond_ok;
                    next_pc = cond_ok ? ir.imm : next_pc;
                end
                TCPU_OP_RETURN: begin
                    branch = cond_ok;
                    do_pop = cond_ok;
                    next_pc = cond_ok ? 8'(stack_top + 8'h01) : next_pc;
                end
                TCPU_OP_INTERRUPT_RETURN: begin
                    branch = 1'b1;
                    do_pop = 1'b1;
                    next_pc = stack_top;
                end
                default: begin
                end
            endcase
        end
        next_zero = (next_result == 8'h00);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 1'b0;
        end else if (phase || run) begin
            phase <= !phase;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir <= '0;
            take_int <= 1'b0;
        end else if (!phase && run) begin
            ir <= fetched;
            take_int <= fetch_int;
        end
    end
    // Port address, data and strobes for the execute cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_number <= 8'h00;
            out_port <= 8'h00;
            read_strobe <= 1'b0;
            write_strobe <= 1'b0;
        end else if (!phase && run) begin
            port_number <= fetched.op[TCPU_OP_REG_BIT] ? fetch_src : fetched.imm;
            out_port <= regs[fetched.dst];
            read_strobe <= !fetch_int && (fetched.op | 5'h08) == (TCPU_OP_INPUT_K | 5'h08);
            write_strobe <= !fetch_int && (fetched.op | 5'h08) == (TCPU_OP_OUTPUT_K | 5'h08);
        end else begin
            read_strobe <= 1'b0;
            write_strobe <= 1'b0;
        end
    end
    // Counter steps and wraps; branches load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= 8'h00;
        end else if (phase) begin
            pc <= take_int ? TCPU_INT_VECTOR : next_pc;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp <= '0;
        end else if (phase && (take_int || do_push)) begin
            sp <= SPW'(sp + 1'b1);
        end else if (phase && do_pop) begin
            sp <= SPW'(sp - 1'b1);
        end
    end
    // Separate stack; full push overwrites oldest
    generate
        for (genvar e = 0; e < STACK_DEPTH; e++) begin : g_stack
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stack[e] <= 8'h00;
                end else if (phase && (take_int || do_push) && sp == SPW'(e)) begin
                    stack[e] <= pc;
                end
            end
        end
        for (genvar r = 0; r < 8; r++) begin : g_regs
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    regs[r] <= 8'h00;
                end else if (phase && !take_int && reg_wr && ir.dst == 3'(r)) begin
                    regs[r] <= next_result;
                end
            end
        end
    endgenerate

    // Flags and interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero <= 1'b0;
            carry <= 1'b0;
            int_enable <= 1'b0;
            saved_zero <= 1'b0;
            saved_carry <= 1'b0;
        end else if (phase) begin
            if (take_int) begin
                saved_zero <= zero;
                saved_carry <= carry;
                int_enable <= 1'b0;
            end else if (ir.op == TCPU_OP_INTERRUPT_RETURN) begin
                zero <= saved_zero;
                carry <= saved_carry;
                int_enable <= ir.imm[0];
            end else if (ir.op == TCPU_OP_INTCTL) begin
                int_enable <= ir.imm[0];
            end else if (flag_wr) begin
                zero <= next_zero;
                carry <= next_carry;
            end
        end
    end

    assign instr_addr = pc;
    // APB slave: one wait state, unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= TCPU_CTRL_RUN_RESET;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            case (paddr)
                TCPU_REG_CTRL: begin
                    if (pwrite) begin
                        run <= pwdata[TCPU_CTRL_RUN_BIT];
                    end else begin
                        prdata[TCPU_CTRL_RUN_BIT] <= run;
                    end
                end
                TCPU_REG_STATUS: begin
                    prdata[7:0] <= pc;
                    prdata[TCPU_STAT_ZERO_BIT] <= zero;
                    prdata[TCPU_STAT_CARRY_BIT] <= carry;
                    prdata[TCPU_STAT_IE_BIT] <= int_enable;
                    prdata[TCPU_STAT_SP_LSB +: SPW] <= sp;
                    pslverr <= pwrite;
                end
                TCPU_REG_GPR_LO: begin
                    prdata <= {regs[3], regs[2], regs[1], regs[0]};
                    pslverr <= pwrite;
                end
                TCPU_REG_GPR_HI: begin
                    prdata <= {regs[7], regs[6], regs[5], regs[4]};
                    pslverr <= pwrite;
                end
                default: begin
                    pslverr <= 1'b1;
                end
            endcase
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    a_phase_alternates: assert property (
        @(posedge pclk) disable iff (!presetn) phase |=> !phase)
        else $error("execute cycle not followed by fetch");
    a_pc_steps_one: assert property (
        @(posedge pclk) disable iff (!presetn)
        (phase && !take_int && !branch) |=> pc == 8'($past(pc) + 8'h01))
        else $error("counter did not step by one");
    a_jump_keeps_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        (phase && !take_int && ir.op == TCPU_OP_JUMP)
        |=> zero == $past(zero) && carry == $past(carry)
            && pc == ($past(cond_ok) ? $past(ir.imm) : 8'($past(pc) + 8'h01)))
        else $error("jump changed flags or wrong target");
    a_call_pushes: assert property (
        @(posedge pclk) disable iff (!presetn)
        (phase && !take_int && ir.op == TCPU_OP_CALL && cond_ok)
        |=> sp == SPW'($past(sp) + 1'b1) && stack[$past(sp)] == $past(pc))
        else $error("call did not push the counter");
    a_load_keeps_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        (phase && !take_int && ir.op[4] == 1'b0 && ir.op[2:0] == 3'h0)
        |=> zero == $past(zero) && carry == $past(carry))
        else $error("load changed a flag");
    a_xor_clears_carry: assert property (
        @(posedge pclk) disable iff (!presetn)
        (phase && !take_int && (ir.op | 5'h08) == (TCPU_OP_XOR_K | 5'h08)) |=> !carry)
        else $error("xor left carry set");
    a_write_strobe_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(write_strobe) |-> phase ##1 !write_strobe)
        else $error("write strobe not a single execute-cycle pulse");
    a_read_strobe_phase: assert property (
        @(posedge pclk) disable iff (!presetn)
        read_strobe |-> phase && !take_int && !write_strobe)
        else $error("read strobe outside an input execute cycle");
    a_int_vector_taken: assert property (
        @(posedge pclk) disable iff (!presetn)
        (phase && take_int) |=> pc == TCPU_INT_VECTOR && !int_enable
            && saved_zero == $past(zero) && saved_carry == $past(carry))
        else $error("interrupt entry incomplete");
    a_interrupt_return_restores: assert property (
        @(posedge pclk) disable iff (!presetn)
        (phase && !take_int && ir.op == TCPU_OP_INTERRUPT_RETURN)
        |=> pc == $past(stack_top) && zero == $past(saved_zero)
            && int_enable == $past(ir.imm[0]))
        else $error("interrupt return mismatch");
endmodule : tcpu_core

// File: design/tcpu_pkg.sv
// Overview of operation
// - Register selectors name eight registers; constants, targets, ports are 8-bit.
// - Program counter advances by one per non-branching instruction, wrapping ff to 00.
// - Conditional jump loads target only when its flag test passes; flags untouched.
// - Call, possibly conditional, pushes current counter, loads target, flags untouched.
// - Return stack is a separate four-entry buffer shared with interrupts.
// - Push onto a full stack overwrites the oldest entry.
// - Passing conditional return loads top stack entry plus one; flags untouched.
// - Stack pointer wraps cyclically; unmatched returns take whatever slot holds.
// - Shifts fill vacated bit with zero, one, copied end bit, or carry.
// - Rotates feed the leaving bit into the other end; shifts/rotates update flags.
// - Load copies constant or register into destination, flags untouched.
// - Loading a register with itself is a two-cycle no-operation.
// - AND combines destination with register or constant, writes back, updates flags.
// - OR writes destination; OR with 00 clears carry and tests zero.
// - XOR writes destination, updates zero, always clears carry.
// - ADD stores 8-bit unsigned sum and updates flags.
// - Add with carry adds operands plus carry, stores, updates flags.
// - Subtract variants remove operand (plus carry) from destination, update flags.
// - Input drives port address, captures port data, pulses read strobe, flags kept.
// - Output drives address and data with write strobe; capture only during strobe.
// - Interrupt return pops top without increment, restores flags, sets enable by operand.
// - Enable and disable instructions set and clear interrupt enable; vector is ff.
// - Every instruction takes exactly two clock cycles.
// - Interrupt saves flags, disables interrupts, calls ff; masked after reset.
package tcpu_pkg;
    // Instruction layout: opcode, destination, constant / target / port / source
    typedef struct packed {
        logic [4:0] op;
        logic [2:0] dst;
        logic [7:0] imm;
    } tcpu_instr_type;

    localparam int unsigned TCPU_INSTR_W = 16;
    localparam int unsigned TCPU_STACK_DEPTH = 4;
    localparam int unsigned TCPU_CLK_PERIOD_NS = 10;
    localparam int unsigned TCPU_INSTR_CYCLES = 2;
    localparam logic [7:0] TCPU_INT_VECTOR = 8'hff;

    // Opcodes; bit 3 of an ALU or port opcode selects a register source
    localparam logic [4:0] TCPU_OP_LOAD_K = 5'h00;
    localparam logic [4:0] TCPU_OP_AND_K = 5'h01;
    localparam logic [4:0] TCPU_OP_OR_K = 5'h02;
    localparam logic [4:0] TCPU_OP_XOR_K = 5'h03;
    localparam logic [4:0] TCPU_OP_ADD_K = 5'h04;
    localparam logic [4:0] TCPU_OP_ADD_WITH_CARRY_K = 5'h05;
    localparam logic [4:0] TCPU_OP_SUB_K = 5'h06;
    localparam logic [4:0] TCPU_OP_SUBTRACT_WITH_BORROW_K = 5'h07;
    localparam logic [4:0] TCPU_OP_RETURN = 5'h12;
    localparam logic [4:0] TCPU_OP_SHIFT = 5'h13;
    localparam logic [4:0] TCPU_OP_INPUT_K = 5'h14;
    localparam logic [4:0] TCPU_OP_OUTPUT_K = 5'h15;
    localparam logic [4:0] TCPU_OP_INTERRUPT_RETURN = 5'h16;
    localparam logic [4:0] TCPU_OP_INTCTL = 5'h17;
    localparam logic [4:0] TCPU_OP_JUMP = 5'h1a;
    localparam logic [4:0] TCPU_OP_CALL = 5'h1b;
    localparam int unsigned TCPU_OP_REG_BIT = 3;

    // Condition codes in the destination field
    localparam logic [2:0] TCPU_COND_ALWAYS = 3'h0;
    localparam logic [2:0] TCPU_COND_Z = 3'h4;
    localparam logic [2:0] TCPU_COND_NZ = 3'h5;
    localparam logic [2:0] TCPU_COND_C = 3'h6;
    localparam logic [2:0] TCPU_COND_NC = 3'h7;

    // Shift selector in imm[3:0]: bit 3 left, bits 2:0 fill kind
    localparam int unsigned TCPU_SHIFT_LEFT_BIT = 3;
    localparam logic [2:0] TCPU_FILL_ZERO = 3'h0;
    localparam logic [2:0] TCPU_FILL_ONE = 3'h1;
    localparam logic [2:0] TCPU_FILL_END = 3'h2;
    localparam logic [2:0] TCPU_FILL_CARRY = 3'h3;
    localparam logic [2:0] TCPU_FILL_ROTATE = 3'h4;
    localparam int unsigned TCPU_SRC_LSB = 5;

    // APB register map
    localparam int unsigned TCPU_ADDR_W = 12;
    localparam logic [11:0] TCPU_REG_CTRL = 12'h000;
    localparam logic [11:0] TCPU_REG_STATUS = 12'h004;
    localparam logic [11:0] TCPU_REG_GPR_LO = 12'h008;
    localparam logic [11:0] TCPU_REG_GPR_HI = 12'h00c;
    localparam int unsigned TCPU_CTRL_RUN_BIT = 0;
    localparam logic TCPU_CTRL_RUN_RESET = 1'b1;
    localparam int unsigned TCPU_STAT_ZERO_BIT = 8;
    localparam int unsigned TCPU_STAT_CARRY_BIT = 9;
    localparam int unsigned TCPU_STAT_IE_BIT = 10;
    localparam int unsigned TCPU_STAT_SP_LSB = 12;
endpackage : tcpu_pkg

// File: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import tcpu_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, interrupt = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, read_strobe, write_strobe, er;
    logic [7:0] instr_addr, port_number, out_port, in_port;
    logic [15:0] instr_data = 16'h4000;
    int n_fail = 0, n_compared = 0, sp;
    logic [7:0] r [8], stk [4], mem [256], pc, a, b, res, pt, f;
    logic [4:0] ctl [10] = '{5'h12, 5'h13, 5'h14, 5'h1c, 5'h15, 5'h1d, 5'h16, 5'h17, 5'h1a, 5'h1b};
    logic [2:0] cnd [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
    logic z, c, ie, sz, sc, cy, t, ers, ews;
    tcpu_instr_type ins;

    tcpu_core DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .instr_addr, .instr_data, .port_number, .out_port, .in_port,
        .read_strobe, .write_strobe, .interrupt);
    tcpu_port_model u_port (.pclk, .port_number, .out_port, .write_strobe, .in_port);

    initial begin
        forever #5 pclk = ~pclk;
    end

    task report_and_stop;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Setup, then access held until pready is sampled high
    task apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20) begin
            n_fail++;
            report_and_stop();
        end
    endtask : apb

    initial begin
        void'($urandom(32'hd947c689));
        r = '{default: 8'h00};
        stk = '{default: 8'h00};
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
        {z, c, ie, sz, sc, sp, pc} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int n = 0; n < 400; n++) begin
            ins = tcpu_instr_type'(16'($urandom));
            ins.op = ($urandom % 2) ? 5'($urandom % 16) : ctl[$urandom % 10];
            if (ins.op inside {5'h12, 5'h1a, 5'h1b}) ins.dst = cnd[$urandom % 5];
            if (ins.op == 5'h13) ins.imm[2:0] = 3'($urandom % 5);
            instr_data <= ins;
            interrupt <= ($urandom % 16 == 0);
            #1 chk(instr_addr, pc);
            @(posedge pclk);
            #1;
            {ers, ews} = '0;
            a = r[ins.dst];
            b = ins.op[3] ? r[ins.imm[7:5]] : ins.imm;
            case (ins.dst)
                3'h0: t = 1'b1;
                3'h4: t = z;
                3'h5: t = !z;
                3'h6: t = c;
                default: t = !c;
            endcase
            if (ie && interrupt) begin
                sp = (sp + 1) % 4;
                stk[sp] = pc;
                {sz, sc, ie, pc} = {z, c, 1'b0, 8'hff};
            end else begin
                pc = pc + 8'h01;
                case (ins.op)
                    5'h12: if (t) begin
                        pc = stk[sp] + 8'h01;
                        sp = (sp + 3) % 4;
                    end
                    5'h1a: if (t) pc = ins.imm;
                    5'h1b: if (t) begin
                        sp = (sp + 1) % 4;
                        stk[sp] = pc - 8'h01;
                        pc = ins.imm;
                    end
                    5'h16: begin
                        pc = stk[sp];
                        sp = (sp + 3) % 4;
                        {z, c, ie} = {sz, sc, ins.imm[0]};
                    end
                    5'h17: ie = ins.imm[0];
                    5'h14, 5'h1c: {ers, pt, r[ins.dst]} = {1'b1, b, mem[b]};
                    5'h15, 5'h1d: {ews, pt, mem[b]} = {1'b1, b, a};
                    5'h13: begin
                        f = {7'h0, ins.imm[2:0] == 3'h1};
                        if (ins.imm[2:0] == 3'h3) f = {7'h0, c};
                        if (ins.imm[2:0] == 3'h2) f = {7'h0, ins.imm[3] ? a[0] : a[7]};
                        if (ins.imm[2:0] == 3'h4) f = {7'h0, ins.imm[3] ? a[7] : a[0]};
                        {cy, res} = ins.imm[3] ? {a, f[0]} : {a[0], f[0], a[7:1]};
                        {r[ins.dst], c, z} = {res, cy, res == 8'h00};
                    end
                    default: begin
                        case (ins.op[2:0])
                            3'h0: {cy, res} = {c, b};
                            3'h1: {cy, res} = {1'b0, a & b};
                            3'h2: {cy, res} = {1'b0, a | b};
                            3'h3: {cy, res} = {1'b0, a ^ b};
                            3'h4: {cy, res} = {1'b0, a} + {1'b0, b};
                            3'h5: {cy, res} = {1'b0, a} + {1'b0, b} + c;
                            3'h6: {cy, res} = {1'b0, a} - {1'b0, b};
                            default: {cy, res} = {1'b0, a} - {1'b0, b} - c;
                        endcase
                        r[ins.dst] = res;
                        if (ins.op[2:0] != 3'h0) {c, z} = {cy, res == 8'h00};
                    end
                endcase
            end
            chk(read_strobe, ers);
            chk(write_strobe, ews);
            if (ers || ews) chk(port_number, pt);
            if (ews) chk(out_port, a);
            @(posedge pclk);
        end
        instr_data <= 16'h4000;
        interrupt <= 1'b0;
        $display("program test done, failed %0d", n_fail);
        apb(1'b0, TCPU_REG_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, TCPU_REG_CTRL, 32'h0);
        apb(1'b0, TCPU_REG_STATUS, 32'h0);
        chk(rd[10:8], {ie, c, z});
        apb(1'b0, TCPU_REG_GPR_LO, 32'h0);
        chk(rd, {r[3], r[2], r[1], r[0]});
        apb(1'b0, TCPU_REG_GPR_HI, 32'h0);
        chk(rd, {r[7], r[6], r[5], r[4]});
        apb(1'b1, TCPU_REG_STATUS, 32'h0);
        chk(er, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        $display("register test done, failed %0d", n_fail);
        report_and_stop();
    end
endmodule : tb_top

// File: verif/tcpu_port_model.sv
`timescale 1ns/100ps
module tcpu_port_model (
    // Port bus from the core
    input wire logic pclk,
    input wire logic [7:0] port_number,
    input wire logic [7:0] out_port,
    input wire logic write_strobe,
    // Decoded data back
    output logic [7:0] in_port
);
    logic [7:0] store [256];
    initial begin
        for (int i = 0; i < 256; i++) begin
            store[i] = 8'(i) ^ 8'h3c;
        end
    end
    always @(posedge pclk) begin
        if (write_strobe) begin
            store[port_number] <= out_port;
        end
    end
    assign in_port = store[port_number];
endmodule : tcpu_port_model
